/* File: oad_pkg.sv */
package oad_pkg;
    // addressing kinds
    localparam logic [1:0] MOD_NODISP = 2'h0;
    localparam logic [1:0] MOD_DISP8  = 2'h1;
    localparam logic [1:0] MOD_DISP32 = 2'h2;
    localparam logic [1:0] MOD_REG    = 2'h3;
    // field positions
    localparam int MOD_HI  = 7;
    localparam int MOD_LO  = 6;
    localparam int REG_HI  = 5;
    localparam int REG_LO  = 3;
    localparam int RM_HI   = 2;
    localparam int RM_LO   = 0;
    localparam int SS_HI   = 7;
    localparam int SS_LO   = 6;
    localparam int IDX_HI  = 5;
    localparam int IDX_LO  = 3;
    localparam int BASE_HI = 2;
    localparam int BASE_LO = 0;
    // special codes
    localparam logic [2:0] CODE_SIB   = 3'h4;
    localparam logic [2:0] IDX_NONE   = 3'h4;
    localparam logic [2:0] CODE_ESP   = 3'h4;
    localparam logic [2:0] CODE_EBP   = 3'h5;
    localparam logic [1:0] SS_X1      = 2'h0;
    // reset values
    localparam logic [3:0] RST_SEG    = 4'h0;
    localparam logic [2:0] RST_DISP   = 3'h0;
    localparam logic [31:0] RST_WORD  = 32'h0;

    typedef enum logic [2:0] {
        SEG_ES,
        SEG_CS,
        SEG_SS,
        SEG_DS,
        SEG_FS,
        SEG_GS,
        SEG_UNDEF
    } oad_seg_e;

    typedef enum logic [1:0] {
        OSZ_BYTE,
        OSZ_WORD,
        OSZ_DWORD
    } oad_osz_e;

    typedef enum logic [1:0] {
        DSZ_NONE,
        DSZ_ONE,
        DSZ_TWO,
        DSZ_FOUR
    } oad_dsz_e;
endpackage

/* File: oad_gpr_map.sv */
`timescale 1ns/1ps
// register code plus width to register file port
module oad_gpr_map (
    input  wire logic [2:0]       code,
    input  wire logic             wide,
    input  wire logic             op32,
    output oad_pkg::oad_osz_e     size,
    output logic      [2:0]       regNum,
    output logic                  highByte
);
    always_comb begin
        if (!wide) begin
            size     = oad_pkg::OSZ_BYTE;
            regNum   = {1'b0, code[1:0]};
            highByte = code[2];
        end else begin
            size     = op32 ? oad_pkg::OSZ_DWORD : oad_pkg::OSZ_WORD;
            regNum   = code;
            highByte = 1'b0;
        end
    end
endmodule

/* File: oad_seg_map.sv */
`timescale 1ns/1ps
// segment selector field decode
module oad_seg_map (
    input  wire logic [2:0]   code,
    input  wire logic         isThreeBit,
    output oad_pkg::oad_seg_e seg,
    output logic              segValid
);
    always_comb begin
        seg      = oad_pkg::SEG_UNDEF;
        segValid = 1'b1;
        if (!isThreeBit) begin
            case (code[1:0])
                2'h0: seg = oad_pkg::SEG_ES;
                2'h1: seg = oad_pkg::SEG_CS;
                2'h2: seg = oad_pkg::SEG_SS;
                default: seg = oad_pkg::SEG_DS;
            endcase
        end else begin
            case (code)
                3'h0: seg = oad_pkg::SEG_ES;
                3'h1: seg = oad_pkg::SEG_CS;
                3'h2: seg = oad_pkg::SEG_SS;
                3'h3: seg = oad_pkg::SEG_DS;
                3'h4: seg = oad_pkg::SEG_FS;
                3'h5: seg = oad_pkg::SEG_GS;
                default: begin
                    seg      = oad_pkg::SEG_UNDEF;
                    segValid = 1'b0;
                end
            endcase
        end
    end
endmodule

/* File: oad_decode.sv */
`timescale 1ns/1ps
// Function
// [RULE1] mod 11 makes rm a register selector chosen by w and width.
// [RULE2] reg field picks a general register by width and w.
// [RULE3] w=0 codes 000..111 give AL CL DL BL AH CH DH BH.
// [RULE4] w=1, 16-bit: AX CX DX BX SP BP SI DI.
// [RULE5] w=1, 32-bit: EAX ECX EDX EBX ESP EBP ESI EDI.
// [RULE6] 2-bit segment: 00 ES, 01 CS, 10 SS, 11 DS.
// [RULE7] 3-bit segment: ES CS SS DS FS GS for 000..101.
// [RULE8] 3-bit codes 110, 111 are undefined segments.
// [RULE9] sib byte yields scale, index and base selectors.
// [RULE10] scale 00 x1, 01 x2, 10 x4, 11 x8.
// [RULE11] index value times scale is an offset component.
// [RULE12] index 000..111 names EAX..EDI, 100 means no index.
// [RULE13] with no index the stream must carry scale 00.
// [RULE14] mod from modrm bits 7:6, base from sib bits 2:0.
// [RULE15] with sib, mod and base decide form, not rm.
// [RULE16] mod 00 sib: base+index, DS; ESP uses SS; base 101 is disp32.
// [RULE17] mod 01 sib: plus disp8; ESP and EBP bases use SS.
// [RULE18] mod 10 sib: plus disp32, same segments as mod 01.
// [RULE19] displacement sizes are one, two or four bytes.
// [RULE20] 32-bit address, mod not 11 and rm 100: sib follows.
// [RULE21] disp8 sign-extended before the add.
module oad_decode (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    input  wire logic [7:0]       modrmByte,
    input  wire logic [7:0]       sibByte,
    input  wire logic             wBit,
    input  wire logic             op32,
    input  wire logic             addr32,
    input  wire logic [2:0]       segField,
    input  wire logic             segIsThreeBit,
    input  wire logic [31:0]      dispIn,
    input  wire logic [31:0]      baseVal,
    input  wire logic [31:0]      indexVal,
    output logic                  outValid,
    output logic                  isRegForm,
    output logic                  sibNeeded,
    output logic [2:0]            rmReg,
    output logic                  rmHigh,
    output oad_pkg::oad_osz_e     rmSize,
    output logic [2:0]            regReg,
    output logic                  regHigh,
    output oad_pkg::oad_osz_e     regSize,
    output oad_pkg::oad_seg_e     selSeg,
    output logic                  selSegValid,
    output oad_pkg::oad_seg_e     defSeg,
    output logic [1:0]            scaleCode,
    output logic [3:0]            scaleFactor,
    output logic                  indexUsed,
    output logic [2:0]            indexReg,
    output logic                  baseUsed,
    output logic [2:0]            baseReg,
    output oad_pkg::oad_dsz_e     dispSize,
    output logic [31:0]           dispExt,
    output logic [31:0]           effOffset,
    output logic                  eaUndefined
);
    typedef struct packed {
        logic              valid;
        logic              regForm;
        logic              sib;
        logic [2:0]        rmReg;
        logic              rmHigh;
        oad_pkg::oad_osz_e rmSize;
        logic [2:0]        regReg;
        logic              regHigh;
        oad_pkg::oad_osz_e regSize;
        oad_pkg::oad_seg_e selSeg;
        logic              selSegValid;
        oad_pkg::oad_seg_e defSeg;
        logic [1:0]        scaleCode;
        logic [3:0]        scaleFactor;
        logic              indexUsed;
        logic [2:0]        indexReg;
        logic              baseUsed;
        logic [2:0]        baseReg;
        oad_pkg::oad_dsz_e dispSize;
        logic [31:0]       dispExt;
        logic [31:0]       effOffset;
        logic              eaUndef;
    } oad_state_s;

    oad_state_s        st_q;
    oad_state_s        st_d;

    logic [1:0]        modF;
    logic [2:0]        rmF;
    logic [2:0]        regF;
    logic [1:0]        ssF;
    logic [2:0]        idxF;
    logic [2:0]        baseF;
    oad_pkg::oad_osz_e rmSizeC;
    oad_pkg::oad_osz_e regSizeC;
    logic [2:0]        rmRegC;
    logic [2:0]        regRegC;
    logic              rmHighC;
    logic              regHighC;
    oad_pkg::oad_seg_e segC;
    logic              segValidC;

    assign modF  = modrmByte[oad_pkg::MOD_HI:oad_pkg::MOD_LO]; // RULE14
    assign rmF   = modrmByte[oad_pkg::RM_HI:oad_pkg::RM_LO];
    assign regF  = modrmByte[oad_pkg::REG_HI:oad_pkg::REG_LO];
    assign ssF   = sibByte[oad_pkg::SS_HI:oad_pkg::SS_LO]; // RULE9
    assign idxF  = sibByte[oad_pkg::IDX_HI:oad_pkg::IDX_LO];
    assign baseF = sibByte[oad_pkg::BASE_HI:oad_pkg::BASE_LO]; // RULE14

    // rm as register (mod 11)
    oad_gpr_map uRmMap (
        .code     (rmF),
        .wide     (wBit),
        .op32     (op32),
        .size     (rmSizeC),
        .regNum   (rmRegC),
        .highByte (rmHighC)
    );

    oad_gpr_map uRegMap (
        .code     (regF),
        .wide     (wBit),
        .op32     (op32),
        .size     (regSizeC),
        .regNum   (regRegC),
        .highByte (regHighC)
    );

    oad_seg_map uSegMap (
        .code       (segField),
        .isThreeBit (segIsThreeBit),
        .seg        (segC),
        .segValid   (segValidC)
    );

    always_comb begin
        logic [31:0] scaled;
        logic [31:0] baseTerm;
        scaled   = RST_WORD_F();
        baseTerm = RST_WORD_F();
        st_d = st_q;
        st_d.valid       = inValid;
        st_d.regForm     = (modF == oad_pkg::MOD_REG); // RULE1
        st_d.sib         = addr32 && (modF != oad_pkg::MOD_REG) && (rmF == oad_pkg::CODE_SIB); // RULE20
        st_d.rmReg       = rmRegC; // RULE1 RULE3 RULE4 RULE5
        st_d.rmHigh      = rmHighC;
        st_d.rmSize      = rmSizeC;
        st_d.regReg      = regRegC; // RULE2 RULE3 RULE4 RULE5
        st_d.regHigh     = regHighC;
        st_d.regSize     = regSizeC;
        st_d.selSeg      = segC; // RULE6 RULE7
        st_d.selSegValid = segValidC; // RULE8
        st_d.scaleCode   = ssF;
        st_d.scaleFactor = 4'h1 << ssF; // RULE10
        st_d.indexUsed   = 1'b0;
        st_d.indexReg    = idxF;
        st_d.baseUsed    = 1'b0;
        st_d.baseReg     = rmF;
        st_d.defSeg      = oad_pkg::SEG_DS;
        st_d.dispSize    = oad_pkg::DSZ_NONE;
        st_d.eaUndef     = 1'b0;
        if (st_d.regForm) begin
            st_d.dispSize = oad_pkg::DSZ_NONE;
        end else if (st_d.sib) begin
            // form set by mod and base only
            st_d.indexUsed = (idxF != oad_pkg::IDX_NONE); // RULE12
            st_d.eaUndef   = (idxF == oad_pkg::IDX_NONE) && (ssF != oad_pkg::SS_X1); // RULE13
            st_d.baseReg   = baseF; // RULE15
            st_d.baseUsed  = 1'b1;
            case (modF)
                oad_pkg::MOD_NODISP: begin
                    if (baseF == oad_pkg::CODE_EBP) begin
                        st_d.baseUsed = 1'b0; // RULE16
                        st_d.dispSize = oad_pkg::DSZ_FOUR;
                    end
                    st_d.defSeg = (baseF == oad_pkg::CODE_ESP) ? oad_pkg::SEG_SS : oad_pkg::SEG_DS; // RULE16
                end
                oad_pkg::MOD_DISP8: begin
                    st_d.dispSize = oad_pkg::DSZ_ONE; // RULE17
                    st_d.defSeg   = (baseF == oad_pkg::CODE_ESP || baseF == oad_pkg::CODE_EBP)
                                    ? oad_pkg::SEG_SS : oad_pkg::SEG_DS; // RULE17
                end
                default: begin
                    st_d.dispSize = oad_pkg::DSZ_FOUR; // RULE18
                    st_d.defSeg   = (baseF == oad_pkg::CODE_ESP || baseF == oad_pkg::CODE_EBP)
                                    ? oad_pkg::SEG_SS : oad_pkg::SEG_DS; // RULE18
                end
            endcase
        end else if (addr32) begin
            st_d.baseUsed = 1'b1;
            case (modF)
                oad_pkg::MOD_NODISP: begin
                    if (rmF == oad_pkg::CODE_EBP) begin
                        st_d.baseUsed = 1'b0;
                        st_d.dispSize = oad_pkg::DSZ_FOUR;
                    end
                end
                oad_pkg::MOD_DISP8: begin
                    st_d.dispSize = oad_pkg::DSZ_ONE;
                    if (rmF == oad_pkg::CODE_EBP) st_d.defSeg = oad_pkg::SEG_SS;
                end
                default: begin
                    st_d.dispSize = oad_pkg::DSZ_FOUR;
                    if (rmF == oad_pkg::CODE_EBP) st_d.defSeg = oad_pkg::SEG_SS;
                end
            endcase
        end else begin
            // 16-bit forms: base and index use flags, displacement size and segment
            st_d.baseUsed = !(modF == oad_pkg::MOD_NODISP && rmF == 3'h6);
            st_d.indexUsed = (rmF[2] == 1'b0);
            if (rmF == 3'h2 || rmF == 3'h3 || (rmF == 3'h6 && modF != oad_pkg::MOD_NODISP))
                st_d.defSeg = oad_pkg::SEG_SS;
            case (modF)
                oad_pkg::MOD_NODISP: st_d.dispSize = (rmF == 3'h6) ? oad_pkg::DSZ_TWO : oad_pkg::DSZ_NONE;
                oad_pkg::MOD_DISP8:  st_d.dispSize = oad_pkg::DSZ_ONE;
                default:             st_d.dispSize = oad_pkg::DSZ_TWO;
            endcase
        end
        case (st_d.dispSize) // RULE19
            oad_pkg::DSZ_ONE:  st_d.dispExt = {{24{dispIn[7]}}, dispIn[7:0]}; // RULE21
            oad_pkg::DSZ_TWO:  st_d.dispExt = {{16{dispIn[15]}}, dispIn[15:0]};
            oad_pkg::DSZ_FOUR: st_d.dispExt = dispIn;
            default:           st_d.dispExt = oad_pkg::RST_WORD;
        endcase
        if (st_d.sib && st_d.indexUsed)
            scaled = indexVal << ssF; // RULE11
        if (st_d.baseUsed)
            baseTerm = baseVal;
        st_d.effOffset = st_d.regForm ? oad_pkg::RST_WORD : (baseTerm + scaled + st_d.dispExt);
        if (!inValid) begin
            st_d.valid = 1'b0;
        end
    end

    function automatic logic [31:0] RST_WORD_F();
        return oad_pkg::RST_WORD;
    endfunction

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign outValid    = st_q.valid;
    assign isRegForm   = st_q.regForm;
    assign sibNeeded   = st_q.sib;
    assign rmReg       = st_q.rmReg;
    assign rmHigh      = st_q.rmHigh;
    assign rmSize      = st_q.rmSize;
    assign regReg      = st_q.regReg;
    assign regHigh     = st_q.regHigh;
    assign regSize     = st_q.regSize;
    assign selSeg      = st_q.selSeg;
    assign selSegValid = st_q.selSegValid;
    assign defSeg      = st_q.defSeg;
    assign scaleCode   = st_q.scaleCode;
    assign scaleFactor = st_q.scaleFactor;
    assign indexUsed   = st_q.indexUsed;
    assign indexReg    = st_q.indexReg;
    assign baseUsed    = st_q.baseUsed;
    assign baseReg     = st_q.baseReg;
    assign dispSize    = st_q.dispSize;
    assign dispExt     = st_q.dispExt;
    assign effOffset   = st_q.effOffset;
    assign eaUndefined = st_q.eaUndef;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_reg_form;
        inValid && modrmByte[7:6] == 2'h3 |=> isRegForm && dispSize == oad_pkg::DSZ_NONE;
    endproperty
    a_reg_form: assert property (p_reg_form) else $error("reg form not flagged"); // RULE1

    property p_byte_high;
        inValid && !wBit |=> rmHigh == $past(modrmByte[2]) && regHigh == $past(modrmByte[5]);
    endproperty
    a_byte_high: assert property (p_byte_high) else $error("byte register half wrong"); // RULE3

    property p_word_size;
        inValid && wBit |=> regSize == ($past(op32) ? oad_pkg::OSZ_DWORD : oad_pkg::OSZ_WORD)
            && regReg == $past(modrmByte[5:3]);
    endproperty
    a_word_size: assert property (p_word_size) else $error("word register size wrong"); // RULE4

    property p_seg_undef;
        inValid && segIsThreeBit && segField[2:1] == 2'h3 |=> !selSegValid;
    endproperty
    a_seg_undef: assert property (p_seg_undef) else $error("undefined segment accepted"); // RULE8

    property p_seg2;
        inValid && !segIsThreeBit && segField[1:0] == 2'h2 |=> selSeg == oad_pkg::SEG_SS;
    endproperty
    a_seg2: assert property (p_seg2) else $error("2-bit segment decode wrong"); // RULE6

    property p_scale;
        inValid |=> scaleFactor == (4'h1 << $past(sibByte[7:6]));
    endproperty
    a_scale: assert property (p_scale) else $error("scale factor wrong"); // RULE10

    property p_sib;
        inValid && addr32 && modrmByte[7:6] != 2'h3 && modrmByte[2:0] == 3'h4 |=> sibNeeded;
    endproperty
    a_sib: assert property (p_sib) else $error("sib not expected"); // RULE20

    property p_disp8;
        inValid && modrmByte[7:6] == 2'h1 |=> dispSize == oad_pkg::DSZ_ONE && dispExt[31] == $past(dispIn[7]);
    endproperty
    a_disp8: assert property (p_disp8) else $error("disp byte not extended"); // RULE21

    property p_sib_seg;
        inValid && addr32 && modrmByte[7:6] == 2'h1 && modrmByte[2:0] == 3'h4 && sibByte[2:0] == 3'h5
            |=> defSeg == oad_pkg::SEG_SS;
    endproperty
    a_sib_seg: assert property (p_sib_seg) else $error("ebp base segment wrong"); // RULE17

    property p_noidx;
        inValid && addr32 && modrmByte[2:0] == 3'h4 && modrmByte[7:6] != 2'h3 && sibByte[5:3] == 3'h4
            |=> !indexUsed;
    endproperty
    a_noidx: assert property (p_noidx) else $error("no-index code used an index"); // RULE12

    property p_seg3;
        inValid && segIsThreeBit && segField == 3'h5 |=> selSeg == oad_pkg::SEG_GS && selSegValid;
    endproperty
    a_seg3: assert property (p_seg3) else $error("3-bit segment decode wrong"); // RULE7

    // mod 00 with base 101: displacement replaces the base register
    property p_sib_nobase;
        inValid && addr32 && modrmByte[7:6] == 2'h0 && modrmByte[2:0] == 3'h4 && sibByte[2:0] == 3'h5
            |=> !baseUsed && dispSize == oad_pkg::DSZ_FOUR;
    endproperty
    a_sib_nobase: assert property (p_sib_nobase) else $error("no-base form wrong"); // RULE16

    property p_disp32;
        inValid && addr32 && modrmByte[7:6] == 2'h2 |=> dispSize == oad_pkg::DSZ_FOUR;
    endproperty
    a_disp32: assert property (p_disp32) else $error("long displacement size wrong"); // RULE18

    property p_sib_base;
        inValid && addr32 && modrmByte[7:6] != 2'h3 && modrmByte[2:0] == 3'h4
            |=> baseReg == $past(sibByte[2:0]);
    endproperty
    a_sib_base: assert property (p_sib_base) else $error("base not taken from sib"); // RULE15

    c_reg: cover property (inValid && modrmByte[7:6] == 2'h3);
    c_sib32: cover property (inValid && addr32 && modrmByte[7:6] == 2'h2 && modrmByte[2:0] == 3'h4);
    c_nobase: cover property (inValid && addr32 && modrmByte[7:6] == 2'h0 && sibByte[2:0] == 3'h5);
    c_undef: cover property (inValid && segIsThreeBit && segField == 3'h7);
endmodule

/* File: oad_regfile_model.sv */
`timescale 1ns/1ps
// general register file seen by address generation
module oad_regfile_model (
    input  wire logic [2:0]  code,
    output logic      [31:0] value
);
    // distinct value per register so a wrong pick shows in the sum
    assign value = 32'h1000_0000 + {11'h000, code, 4'h0, code, 8'h00, code};
endmodule

/* File: oad_decode_tb.sv */
`timescale 1ns/1ps
module oad_decode_tb;
    logic                  sys_clk       = 1'b0;
    logic                  rst           = 1'b1;
    logic                  inValid       = 1'b0;
    logic [7:0]            modrmByte     = 8'h00;
    logic [7:0]            sibByte       = 8'h00;
    logic                  wBit          = 1'b0;
    logic                  op32          = 1'b0;
    logic                  addr32        = 1'b0;
    logic [2:0]            segField      = 3'h0;
    logic                  segIsThreeBit = 1'b0;
    logic [31:0]           dispIn        = 32'h0;
    logic [31:0]           baseVal;
    logic [31:0]           indexVal;
    logic                  outValid;
    logic                  isRegForm;
    logic                  sibNeeded;
    logic [2:0]            rmReg;
    logic                  rmHigh;
    oad_pkg::oad_osz_e     rmSize;
    logic [2:0]            regReg;
    logic                  regHigh;
    oad_pkg::oad_osz_e     regSize;
    oad_pkg::oad_seg_e     selSeg;
    logic                  selSegValid;
    oad_pkg::oad_seg_e     defSeg;
    logic [1:0]            scaleCode;
    logic [3:0]            scaleFactor;
    logic                  indexUsed;
    logic [2:0]            indexReg;
    logic                  baseUsed;
    logic [2:0]            baseReg;
    oad_pkg::oad_dsz_e     dispSize;
    logic [31:0]           dispExt;
    logic [31:0]           effOffset;
    logic                  eaUndefined;
    int                    err_total     = 0;
    int                    checks        = 0;

    always #12.5 sys_clk = ~sys_clk;

    oad_regfile_model u_base (.code(sibByte[2:0]), .value(baseVal));
    oad_regfile_model u_index (.code(sibByte[5:3]), .value(indexVal));

    oad_decode u_oad_decode (
        .sys_clk(sys_clk), .rst(rst), .inValid(inValid), .modrmByte(modrmByte),
        .sibByte(sibByte), .wBit(wBit), .op32(op32), .addr32(addr32), .segField(segField),
        .segIsThreeBit(segIsThreeBit), .dispIn(dispIn), .baseVal(baseVal), .indexVal(indexVal),
        .outValid(outValid), .isRegForm(isRegForm), .sibNeeded(sibNeeded), .rmReg(rmReg),
        .rmHigh(rmHigh), .rmSize(rmSize), .regReg(regReg), .regHigh(regHigh), .regSize(regSize),
        .selSeg(selSeg), .selSegValid(selSegValid), .defSeg(defSeg), .scaleCode(scaleCode),
        .scaleFactor(scaleFactor), .indexUsed(indexUsed), .indexReg(indexReg), .baseUsed(baseUsed),
        .baseReg(baseReg), .dispSize(dispSize), .dispExt(dispExt), .effOffset(effOffset),
        .eaUndefined(eaUndefined)
    );

    task automatic final_report;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // inputs change 1 ns after the edge, outputs read 1 ns after the next
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic chk_gpr(input logic [2:0] c, input logic [2:0] r, input logic h, input logic [1:0] s);
        chk("gprSize", wBit ? (op32 ? oad_pkg::OSZ_DWORD : oad_pkg::OSZ_WORD) : oad_pkg::OSZ_BYTE, s);
        chk("gprNum", wBit ? c : {1'b0, c[1:0]}, r);
        chk("gprHigh", !wBit && c[2], h);
    endtask

    task automatic t_regs;
        for (int k = 0; k < 32; k++) begin
            modrmByte = {oad_pkg::MOD_REG, k[2:0], ~k[2:0]};
            wBit = k[3];
            op32 = k[4];
            step();
            chk("isRegForm", 32'h1, isRegForm);
            chk("effOffset", 32'h0, effOffset);
            chk_gpr(~k[2:0], rmReg, rmHigh, rmSize);
            chk_gpr(k[2:0], regReg, regHigh, regSize);
        end
    endtask

    task automatic t_seg;
        for (int k = 0; k < 12; k++) begin
            segIsThreeBit = k < 8;
            // two-bit form carries a stray high bit that must be ignored
            segField = (k < 8) ? k[2:0] : {1'b1, k[1:0]};
            step();
            chk("selSegValid", k != 6 && k != 7, selSegValid);
            if (k != 6 && k != 7) begin
                chk("selSeg", (k < 8) ? k[2:0] : k[1:0], selSeg);
            end
        end
    endtask

    task automatic t_sib;
        logic [31:0]       dx;
        logic [31:0]       ex;
        logic              bu;
        logic [2:0]        b;
        oad_pkg::oad_seg_e sg;
        oad_pkg::oad_dsz_e dz;
        for (int m = 0; m < 3; m++) begin
            for (int i = 0; i < 256; i++) begin
                addr32 = 1'b1;
                modrmByte = {m[1:0], 3'h2, oad_pkg::CODE_SIB};
                sibByte = i[7:0];
                dispIn = i[3] ? 32'h1234_5680 : 32'h8765_437f;
                step();
                b = i[2:0];
                bu = !(m == 0 && b == 3'h5);
                sg = (b == 3'h4 || (m != 0 && b == 3'h5)) ? oad_pkg::SEG_SS : oad_pkg::SEG_DS;
                dz = (m == 1) ? oad_pkg::DSZ_ONE : (bu && m == 0) ? oad_pkg::DSZ_NONE : oad_pkg::DSZ_FOUR;
                dx = (m == 1) ? {{24{dispIn[7]}}, dispIn[7:0]} : (dz == oad_pkg::DSZ_FOUR) ? dispIn : 32'h0;
                ex = (bu ? baseVal : 32'h0) + dx + ((i[5:3] == 4) ? 32'h0 : (indexVal << i[7:6]));
                chk("isRegForm", 32'h0, isRegForm);
                chk("sibNeeded", 32'h1, sibNeeded);
                chk("scaleCode", i[7:6], scaleCode);
                chk("scaleFactor", {i[7:6] == 3, i[7:6] == 2, i[7:6] == 1, i[7:6] == 0}, scaleFactor);
                chk("indexUsed", i[5:3] != 4, indexUsed);
                if (i[5:3] != 4) begin
                    chk("indexReg", i[5:3], indexReg);
                end
                chk("baseUsed", bu, baseUsed);
                if (bu) begin
                    chk("baseReg", b, baseReg);
                end
                chk("defSeg", sg, defSeg);
                chk("dispSize", dz, dispSize);
                if (dz != oad_pkg::DSZ_NONE) begin
                    chk("dispExt", dx, dispExt);
                end
                // scale must be 00 with no index; other scales are flagged
                chk("eaUndefined", i[5:3] == 4 && i[7:6] != 0, eaUndefined);
                if (!(i[5:3] == 4 && i[7:6] != 0)) begin
                    chk("effOffset", ex, effOffset);
                end
            end
        end
    endtask

    task automatic t_form(input logic a, input logic [7:0] m, input logic s, input logic [1:0] d, input logic v);
        addr32 = a;
        modrmByte = m;
        sibByte = 8'h25;
        inValid = v;
        step();
        chk("outValid", v, outValid);
        chk("sibNeeded", s, sibNeeded);
        chk("dispSize", d, dispSize);
    endtask

    initial begin
        #50us;
        err_total++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        chk("outValid", 32'h0, outValid);
        chk("effOffset", 32'h0, effOffset);
        rst = 1'b0;
        inValid = 1'b1;
        t_regs();
        t_seg();
        t_sib();
        t_form(1'b1, 8'hc4, 1'b0, oad_pkg::DSZ_NONE, 1'b0);
        t_form(1'b1, 8'h05, 1'b0, oad_pkg::DSZ_FOUR, 1'b1);
        t_form(1'b1, 8'h45, 1'b0, oad_pkg::DSZ_ONE, 1'b0);
        t_form(1'b0, 8'h04, 1'b0, oad_pkg::DSZ_NONE, 1'b1);
        t_form(1'b0, 8'h06, 1'b0, oad_pkg::DSZ_TWO, 1'b1);
        t_form(1'b0, 8'h84, 1'b0, oad_pkg::DSZ_TWO, 1'b0);
        chk("defSeg", oad_pkg::SEG_DS, defSeg);
        final_report();
    end
endmodule
